// file: design/qdsl_regs.svh
// constants for the quad dac serial load control block
`ifndef QDSL_REGS_SVH
`define QDSL_REGS_SVH
`define QDSL_WORD_BITS 32
`define QDSL_FIFO_DEPTH 32
`define QDSL_LAST_BIT 5'h1f
`define QDSL_CMD_HI 27
`define QDSL_CMD_LO 24
`define QDSL_ADDR_HI 23
`define QDSL_ADDR_LO 20
`define QDSL_DATA_HI 19
`define QDSL_DATA_LO 4
`define QDSL_CMD_WRITE 4'h0
`define QDSL_CMD_UPDATE 4'h1
`define QDSL_CMD_WRITE_UPD 4'h3
`define QDSL_CMD_CLRCODE 4'h5
`define QDSL_ADDR_ALL 4'hf
`define QDSL_CODE_ZERO 16'h0000
`define QDSL_CODE_MID 16'h8000
`define QDSL_CODE_FULL 16'hffff
`define QDSL_CC_ZERO 2'h0
`define QDSL_CC_MID 2'h1
`define QDSL_CC_FULL 2'h2
`define QDSL_CC_RESET 2'h0
`define QDSL_INIT_WAIT 2'h3
`define QDSL_SYNC_RESET 6'h1b
`endif

// file: design/qdsl_pkg.sv
// types for the quad dac serial load control block
package qdsl_pkg;
  typedef enum logic [1:0] {
    QDSL_IDLE = 2'h0,
    QDSL_SHIFT = 2'h1,
    QDSL_HOLD = 2'h3
  } qdsl_frame_e;
  typedef logic [15:0] qdsl_code_t;
endpackage : qdsl_pkg

// file: design/qdsl_fifo.sv
// word fifo between frame capture and command decoder
`timescale 1ns/1ps
module qdsl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage needs no reset, the count guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule : qdsl_fifo

// file: design/qdsl_top.sv
// serial frame capture, command decode and dac register control
`timescale 1ns/1ps
`include "qdsl_regs.svh"
module qdsl_top (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic SYNC_N,
  input wire logic SCLK,
  input wire logic DIN,
  input wire logic LOAD_UPDATE_STROBE_N,
  input wire logic ASYNC_CLEAR_N,
  input wire logic POWERUP_MID,
  output logic [15:0] DAC_A,
  output logic [15:0] DAC_B,
  output logic [15:0] DAC_C,
  output logic [15:0] DAC_D,
  output logic [1:0] CLEAR_CODE,
  output logic FRAME_STALL
);
  // two-flop synchronisers, third stage only for edge finding
  logic [5:0] pin_raw, s1_reg, s2_reg, s3_reg;
  assign pin_raw = {POWERUP_MID, ASYNC_CLEAR_N, LOAD_UPDATE_STROBE_N, DIN, SCLK, SYNC_N};
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s1_reg <= `QDSL_SYNC_RESET;
      s2_reg <= `QDSL_SYNC_RESET;
      s3_reg <= `QDSL_SYNC_RESET;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  logic sync_s, din_s, load_update_strobe_n_s, clr_s, por_s, sync_fall, sclk_fall, clr_fall;
  assign sync_s = s2_reg[0];
  assign din_s = s2_reg[2];
  assign load_update_strobe_n_s = s2_reg[3];
  assign clr_s = s2_reg[4];
  assign por_s = s2_reg[5];
  assign sync_fall = s3_reg[0] && !s2_reg[0];
  assign sclk_fall = s3_reg[1] && !s2_reg[1];
  assign clr_fall = s3_reg[4] && !s2_reg[4];

  // frame capture
  qdsl_pkg::qdsl_frame_e st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [31:0] sh_reg, sh_next, word_reg, word_next;
  logic pend_reg, pend_next;
  logic f_in_ready, f_out_valid, f_pop;
  logic [31:0] f_out_data;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    word_next = word_reg;
    pend_next = pend_reg;
    if (pend_reg && f_in_ready) begin
      pend_next = 1'b0;
    end
    case (st_reg)
      qdsl_pkg::QDSL_IDLE: begin
        // a frame opening while a word still waits for room is not taken
        if (sync_fall && !pend_reg) begin
          st_next = qdsl_pkg::QDSL_SHIFT;
          cnt_next = 5'h00;
        end
      end
      qdsl_pkg::QDSL_SHIFT: begin
        if (sync_s) begin
          st_next = qdsl_pkg::QDSL_IDLE;
        end else if (sclk_fall) begin
          sh_next = {sh_reg[30:0], din_s};
          cnt_next = 5'(cnt_reg + 1'b1);
          if (cnt_reg == `QDSL_LAST_BIT) begin
            word_next = {sh_reg[30:0], din_s};
            pend_next = 1'b1;
            st_next = qdsl_pkg::QDSL_HOLD;
          end
        end
      end
      qdsl_pkg::QDSL_HOLD: begin
        // extra edges after the 32nd are ignored until select rises
        if (sync_s) begin
          st_next = qdsl_pkg::QDSL_IDLE;
        end
      end
      default: begin
        st_next = qdsl_pkg::QDSL_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      st_reg <= qdsl_pkg::QDSL_IDLE;
      cnt_reg <= 5'h00;
      sh_reg <= 32'h00000000;
      word_reg <= 32'h00000000;
      pend_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      word_reg <= word_next;
      pend_reg <= pend_next;
    end
  end

  qdsl_fifo #(
    .WIDTH(`QDSL_WORD_BITS),
    .DEPTH(`QDSL_FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst(RESET),
    .in_valid(pend_reg),
    .in_ready(f_in_ready),
    .in_data(word_reg),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  // command decode and channel registers
  qdsl_pkg::qdsl_code_t in_reg [0:3];
  qdsl_pkg::qdsl_code_t in_next [0:3];
  qdsl_pkg::qdsl_code_t dac_reg [0:3];
  qdsl_pkg::qdsl_code_t dac_next [0:3];
  qdsl_pkg::qdsl_code_t clear_val, data_f;
  logic [3:0] new_reg, new_next;
  logic [1:0] cc_reg, cc_next, init_reg, init_next;
  logic [3:0] cmd_f, addr_f;

  assign cmd_f = f_out_data[`QDSL_CMD_HI:`QDSL_CMD_LO];
  assign addr_f = f_out_data[`QDSL_ADDR_HI:`QDSL_ADDR_LO];
  assign data_f = f_out_data[`QDSL_DATA_HI:`QDSL_DATA_LO];

  always_comb begin
    case (cc_reg)
      `QDSL_CC_MID: clear_val = `QDSL_CODE_MID;
      `QDSL_CC_FULL: clear_val = `QDSL_CODE_FULL;
      default: clear_val = `QDSL_CODE_ZERO;
    endcase
  end

  // decoder stalls while clear is low, so the fifo can really fill
  assign f_pop = f_out_valid && clr_s && (init_reg == 2'h0);

  always_comb begin
    in_next = in_reg;
    dac_next = dac_reg;
    new_next = new_reg;
    cc_next = cc_reg;
    init_next = init_reg;
    if (init_reg != 2'h0) begin
      // strap seen only once the synchroniser has settled
      init_next = 2'(init_reg - 1'b1);
      if (init_reg == 2'h1) begin
        for (int i = 0; i < 4; i++) begin
          dac_next[i] = por_s ? `QDSL_CODE_MID : `QDSL_CODE_ZERO;
          in_next[i] = dac_next[i];
        end
      end
    end else if (clr_fall) begin
      for (int i = 0; i < 4; i++) begin
        in_next[i] = clear_val;
        dac_next[i] = clear_val;
        new_next[i] = 1'b0;
      end
    end else begin
      if (f_pop) begin
        for (int i = 0; i < 4; i++) begin
          if (addr_f == `QDSL_ADDR_ALL || addr_f == 4'(i)) begin
            case (cmd_f)
              `QDSL_CMD_WRITE: begin
                in_next[i] = data_f;
                new_next[i] = 1'b1;
              end
              `QDSL_CMD_UPDATE: begin
                dac_next[i] = in_reg[i];
                new_next[i] = 1'b0;
              end
              `QDSL_CMD_WRITE_UPD: begin
                in_next[i] = data_f;
                dac_next[i] = data_f;
                new_next[i] = 1'b0;
              end
              default: begin
              end
            endcase
          end
        end
        if (cmd_f == `QDSL_CMD_CLRCODE) begin
          cc_next = f_out_data[1:0];
        end
      end
      // level acting covers pulsed and tied-low use alike
      if (!load_update_strobe_n_s && clr_s) begin
        for (int i = 0; i < 4; i++) begin
          if (new_next[i]) begin
            dac_next[i] = in_next[i];
            new_next[i] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      for (int i = 0; i < 4; i++) begin
        in_reg[i] <= `QDSL_CODE_ZERO;
        dac_reg[i] <= `QDSL_CODE_ZERO;
      end
      new_reg <= 4'h0;
      cc_reg <= `QDSL_CC_RESET;
      init_reg <= `QDSL_INIT_WAIT;
    end else begin
      for (int i = 0; i < 4; i++) begin
        in_reg[i] <= in_next[i];
        dac_reg[i] <= dac_next[i];
      end
      new_reg <= new_next;
      cc_reg <= cc_next;
      init_reg <= init_next;
    end
  end

  assign DAC_A = dac_reg[0];
  assign DAC_B = dac_reg[1];
  assign DAC_C = dac_reg[2];
  assign DAC_D = dac_reg[3];
  assign CLEAR_CODE = cc_reg;
  assign FRAME_STALL = pend_reg && !f_in_ready;
endmodule : qdsl_top

// file: dv/qdsl_top_checker.sv
// assertions on the serial load control top ports
`timescale 1ns/1ps
module qdsl_top_checker (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic SYNC_N,
  input wire logic SCLK,
  input wire logic DIN,
  input wire logic LOAD_UPDATE_STROBE_N,
  input wire logic ASYNC_CLEAR_N,
  input wire logic POWERUP_MID,
  input wire logic [15:0] DAC_A,
  input wire logic [15:0] DAC_B,
  input wire logic [15:0] DAC_C,
  input wire logic [15:0] DAC_D,
  input wire logic [1:0] CLEAR_CODE,
  input wire logic FRAME_STALL
);
  default clocking @(posedge MCLK); endclocking
  logic [5:0] quiet_reg;
  logic [5:0] quiet_next;
  logic [63:0] dacs;
  logic [15:0] clr_val;
  assign dacs = {DAC_A, DAC_B, DAC_C, DAC_D};
  assign clr_val = (CLEAR_CODE == 2'h1) ? 16'h8000 : (CLEAR_CODE == 2'h2) ? 16'hffff : 16'h0000;
  // 40 idle cycles outlast a full fifo drain
  always_comb begin
    quiet_next = quiet_reg;
    if (RESET || !SYNC_N || !LOAD_UPDATE_STROBE_N || !ASYNC_CLEAR_N) quiet_next = 6'h0;
    else if (quiet_reg != 6'h3f) quiet_next = quiet_reg + 6'h1;
  end
  always_ff @(posedge MCLK) begin
    quiet_reg <= quiet_next;
  end
  sequence rel_s; RESET ##1 !RESET [*3]; endsequence
  sequence clr_fall_s; (ASYNC_CLEAR_N && !RESET) ##1 (!ASYNC_CLEAR_N && !RESET) [*5]; endsequence
  sequence clr_held_s; (!ASYNC_CLEAR_N && !RESET) [*8]; endsequence
  reset_values_a: assert property (RESET |=> dacs == 64'h0 && CLEAR_CODE == 2'h0 && !FRAME_STALL)
    else $error("outputs not cleared by reset");
  strap_level_a: assert property (rel_s |=> RESET || dacs == {4{POWERUP_MID ? 16'h8000 : 16'h0000}})
    else $error("power-up level wrong");
  clr_value_a: assert property (disable iff (RESET) clr_fall_s |-> dacs == {4{clr_val}})
    else $error("clear value not loaded");
  clr_blocks_a: assert property (disable iff (RESET) clr_held_s |-> $stable(dacs))
    else $error("dac changed while clear held");
  clr_code_a: assert property (disable iff (RESET) clr_held_s |-> $stable(CLEAR_CODE))
    else $error("clear code changed while clear held");
  stall_quiet_a: assert property (disable iff (RESET) quiet_reg >= 6'h28 |-> !FRAME_STALL)
    else $error("stall seen on idle link");
  dac_quiet_a: assert property (disable iff (RESET) quiet_reg >= 6'h28 |-> $stable(dacs))
    else $error("dac changed on idle link");
  code_quiet_a: assert property (disable iff (RESET) quiet_reg >= 6'h28 |-> $stable(CLEAR_CODE))
    else $error("clear code changed on idle link");
endmodule : qdsl_top_checker

// file: dv/qdsl_host_model.sv
// host model driving the serial frame pins
`timescale 1ns/1ps
module qdsl_host_model (
  input wire logic clk,
  output logic sync_n,
  output logic sclk,
  output logic din
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // 200 ns serial period, far under the 50 MHz ceiling
  task automatic half_period;
    repeat (4) @(posedge clk);
    #1;
  endtask : half_period
  // n below 32 aborts the frame early
  task automatic send(input logic [31:0] w, input int n);
    half_period();
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = w[31 - i];
      half_period();
      sclk = 1'b0;
      half_period();
      sclk = 1'b1;
    end
    half_period();
    sync_n = 1'b1;
    din = ~din;
    repeat (2) half_period();
  endtask : send
endmodule : qdsl_host_model

// file: dv/tb.sv
// self-checking bench for the serial load control top
`timescale 1ns/1ps
module tb;
  logic mclk, reset, strobe_n, clear_n, powerup_mid, sync_n, sclk, din, frame_stall;
  logic [15:0] dac_a, dac_b, dac_c, dac_d;
  logic [1:0] clear_code;
  int error_cnt = 0;
  int total_checks = 0;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  qdsl_top qdsl_top_i (.MCLK(mclk), .RESET(reset), .SYNC_N(sync_n), .SCLK(sclk), .DIN(din),
    .LOAD_UPDATE_STROBE_N(strobe_n), .ASYNC_CLEAR_N(clear_n), .POWERUP_MID(powerup_mid), .DAC_A(dac_a),
    .DAC_B(dac_b), .DAC_C(dac_c), .DAC_D(dac_d), .CLEAR_CODE(clear_code), .FRAME_STALL(frame_stall));
  qdsl_host_model qdsl_host_model_i (.clk(mclk), .sync_n(sync_n), .sclk(sclk), .din(din));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  function automatic logic [31:0] word(input logic [3:0] cmd, input logic [3:0] ch, input logic [15:0] v);
    return {4'h0, cmd, ch, v, 4'h0};
  endfunction : word
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic do_reset(input logic mid);
    powerup_mid = mid;
    reset = 1'b1;
    cyc(5);
    reset = 1'b0;
    cyc(6);
    chk(dac_a, mid ? 16'h8000 : 16'h0000);
    chk(dac_d, mid ? 16'h8000 : 16'h0000);
    chk({14'h0, clear_code}, 16'h0);
  endtask : do_reset
  // first pass uses the default code after reset
  task automatic t_clear;
    logic [15:0] exp [3] = '{16'h0000, 16'h8000, 16'hffff};
    for (int cc = 0; cc < 3; cc++) begin
      if (cc != 0) qdsl_host_model_i.send(word(4'h5, 4'h0, 16'h0) | cc, 32);
      chk({14'h0, clear_code}, cc[15:0]);
      clear_n = 1'b0;
      cyc(8);
      chk(dac_a, exp[cc]);
      chk(dac_c, exp[cc]);
      clear_n = 1'b1;
      cyc(4);
    end
  endtask : t_clear
  task automatic t_write;
    qdsl_host_model_i.send(word(4'h3, 4'h1, 16'h1234), 32);
    chk(dac_b, 16'h1234);
    chk(dac_a, 16'hffff);
  endtask : t_write
  // one bit short must leave everything alone
  task automatic t_abort;
    qdsl_host_model_i.send(word(4'h3, 4'h0, 16'h1111), 31);
    chk(dac_a, 16'hffff);
    qdsl_host_model_i.send(word(4'h3, 4'h0, 16'h2222), 32);
    chk(dac_a, 16'h2222);
  endtask : t_abort
  task automatic t_strobe;
    qdsl_host_model_i.send(word(4'h0, 4'h2, 16'h0c0c), 32);
    chk(dac_c, 16'hffff);
    strobe_n = 1'b0;
    cyc(2);
    strobe_n = 1'b1;
    cyc(4);
    chk(dac_c, 16'h0c0c);
    strobe_n = 1'b0;
    qdsl_host_model_i.send(word(4'h0, 4'h3, 16'h7e7e), 32);
    chk(dac_d, 16'h7e7e);
    strobe_n = 1'b1;
    cyc(2);
    // all-channel write parks new data, the update command then moves it
    qdsl_host_model_i.send(word(4'h0, 4'hf, 16'h5a5a), 32);
    chk(dac_b, 16'h1234);
    qdsl_host_model_i.send(word(4'h1, 4'hf, 16'h0000), 32);
    chk(dac_a, 16'h5a5a);
    chk(dac_d, 16'h5a5a);
  endtask : t_strobe
  // 33 words against a 32-deep fifo while clear blocks decoding
  task automatic t_fifo;
    clear_n = 1'b0;
    cyc(8);
    for (int i = 0; i < 33; i++) qdsl_host_model_i.send(word(4'h3, 4'h2, i[15:0]), 32);
    chk({15'h0, frame_stall}, 16'h1);
    strobe_n = 1'b0;
    cyc(2);
    strobe_n = 1'b1;
    cyc(4);
    chk(dac_c, 16'hffff);
    clear_n = 1'b1;
    cyc(80);
    chk(dac_c, 16'h0020);
    chk({15'h0, frame_stall}, 16'h0);
  endtask : t_fifo
  initial begin
    #2_000_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    strobe_n = 1'b1;
    clear_n = 1'b1;
    powerup_mid = 1'b1;
    do_reset(1'b1);
    t_clear();
    t_write();
    t_abort();
    t_strobe();
    t_fifo();
    do_reset(1'b0);
    print_verdict();
  end
endmodule : tb
bind qdsl_top qdsl_top_checker qdsl_top_checker_i (.MCLK(MCLK), .RESET(RESET), .SYNC_N(SYNC_N), .SCLK(SCLK),
  .DIN(DIN), .LOAD_UPDATE_STROBE_N(LOAD_UPDATE_STROBE_N), .ASYNC_CLEAR_N(ASYNC_CLEAR_N), .POWERUP_MID(POWERUP_MID),
  .DAC_A(DAC_A), .DAC_B(DAC_B), .DAC_C(DAC_C), .DAC_D(DAC_D), .CLEAR_CODE(CLEAR_CODE), .FRAME_STALL(FRAME_STALL));
